// ---- logic/vtrig_pkg.sv ----
// package for the vertical trigger control block: register map, field codes, modes
// assumes a 32-bit classic wishbone slave and one 125 MHz clock
package vtrig_pkg;
	// register byte offsets
	localparam logic [3:0] MODE_OFS = 4'h0;
	localparam logic [3:0] CMD_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	localparam logic [3:0] LINES_OFS = 4'hC;
	// mode register field positions
	localparam int MODE_LSB = 0;
	localparam int ROUTE_LSB = 4;
	localparam int POLA_BIT = 6;
	localparam int POLB_BIT = 7;
	localparam int SRC_LSB = 8;
	// command register bit positions
	localparam int CMD_SNAP_BIT = 0;
	localparam int CMD_GRAB_BIT = 1;
	localparam int CMD_FREEZE_BIT = 2;
	localparam int CMD_ABORT_BIT = 3;
	localparam int CMD_SWA_BIT = 4;
	localparam int CMD_SWA_LVL_BIT = 5;
	localparam int CMD_SWB_BIT = 6;
	localparam int CMD_SWB_LVL_BIT = 7;
	// reset values
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [1:0] ROUTE_RESET = 2'h0;
	localparam logic [2:0] SRC_RESET = 3'h0;
	localparam logic [15:0] LINES_RESET = 16'h0400;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	typedef enum logic [3:0] {
		mode_untriggered = 4'h0,
		mode_deferred_command = 4'h1,
		mode_grab_hold_window = 4'h2,
		mode_single_frame = 4'h3,
		mode_internal_single_frame = 4'h4,
		mode_window_first_input = 4'h5,
		mode_window_two_inputs = 4'h6,
		mode_window_level_repeat = 4'h7,
		mode_triggered_capture = 4'h8,
		mode_streaming_capture = 4'h9,
		mode_gated_streaming = 4'hA
	} trig_mode_t;

	typedef enum logic [1:0] {
		routing_shared = 2'h0,
		routing_split = 2'h1,
		routing_one_free = 2'h2
	} routing_t;

	typedef enum logic [2:0] {
		source_differential = 3'h0,
		source_single_ended = 3'h1,
		source_isolated = 3'h2,
		source_frame_valid = 3'h3,
		source_internal_generator = 3'h4,
		source_keep = 3'h7
	} source_t;

	localparam logic polarity_rising = 1'b0;
	localparam logic polarity_falling = 1'b1;

	typedef enum logic [1:0] {
		acq_idle = 2'b00,
		acq_armed = 2'b01,
		acq_frame = 2'b10,
		acq_lines = 2'b11
	} acq_state_t;
endpackage

// ---- logic/trig_edge_detect.sv ----
// edge detector for one trigger input with selectable polarity
// assumes the input is synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module trig_edge_detect
	import vtrig_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic trig_i,
	input wire logic polarity_i,
	output logic level_o,
	output logic assert_o,
	output logic deassert_o
);
	logic sync_reg, sync_next;
	logic stage_reg, stage_next;
	logic prev_reg, prev_next;
	logic active;

	// two stage sampler then a history flop
	always_comb begin
		sync_next = trig_i;
		stage_next = sync_reg;
		prev_next = active;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_reg <= 1'b0;
			stage_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			sync_reg <= sync_next;
			stage_reg <= stage_next;
			prev_reg <= prev_next;
		end
	end

	// polarity folds the falling edge onto an assertion
	assign active = stage_reg ^ (polarity_i == polarity_falling);
	assign level_o = active;
	assign assert_o = active & ~prev_reg;
	assign deassert_o = ~active & prev_reg;
endmodule
`default_nettype wire

// ---- logic/engine_window.sv ----
// per engine capture sequencer; one instance for each acquisition engine
// assumes trigger events are one-cycle pulses already polarity-corrected
`timescale 1ns/1ps
`default_nettype none
module engine_window
	import vtrig_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] mode_i,
	input wire logic free_i,
	input wire logic a_level_i,
	input wire logic a_rise_i,
	input wire logic a_fall_i,
	input wire logic b_rise_i,
	input wire logic snap_i,
	input wire logic grab_i,
	input wire logic stop_i,
	input wire logic frame_start_i,
	input wire logic frame_end_i,
	input wire logic line_i,
	input wire logic qual_i,
	input wire logic [15:0] max_lines_i,
	output logic capture_o,
	output logic accept_o,
	output logic pending_o,
	output logic grabbing_o
);
	acq_state_t state_reg, state_next;
	logic grab_reg, grab_next;
	logic cmd_grab_reg, cmd_grab_next;
	logic self_reg, self_next;
	logic [15:0] lines_reg, lines_next;
	trig_mode_t mode;

	assign mode = trig_mode_t'(mode_i);

	// next state of the capture sequencer
	always_comb begin
		state_next = state_reg;
		grab_next = grab_reg;
		cmd_grab_next = cmd_grab_reg;
		self_next = self_reg;
		lines_next = lines_reg;
		if (snap_i) begin
			cmd_grab_next = 1'b0;
		end
		if (grab_i) begin
			cmd_grab_next = 1'b1;
		end
		if (free_i || mode == mode_untriggered) begin
			// ignores triggers
			state_next = acq_frame;
			grab_next = 1'b1;
		end else begin
			case (state_reg)
				acq_idle: begin
					grab_next = 1'b0;
					lines_next = 16'h0000;
					case (mode)
						mode_deferred_command: if (snap_i || grab_i) state_next = acq_armed;
						mode_grab_hold_window: if (a_rise_i) begin
							state_next = acq_frame;
							grab_next = 1'b1;
						end
						mode_single_frame: if (a_rise_i) state_next = acq_armed;
						mode_internal_single_frame: state_next = acq_armed;
						mode_window_first_input, mode_window_two_inputs,
						mode_triggered_capture, mode_window_level_repeat: if (a_rise_i) state_next = acq_lines;
						mode_streaming_capture, mode_gated_streaming: if (a_rise_i) state_next = acq_lines;
						default: state_next = acq_idle;
					endcase
				end
				acq_armed: begin
					// deferred command waits for trigger, then frame start
					if (mode == mode_deferred_command && !self_reg) begin
						if (a_rise_i) self_next = 1'b1;
					end else if (frame_start_i) begin
						state_next = acq_frame;
						grab_next = (mode == mode_deferred_command) && cmd_grab_reg;
						self_next = 1'b0;
					end
				end
				acq_frame: begin
					if (mode == mode_grab_hold_window) begin
						if (a_fall_i) state_next = acq_idle;
					end else if (frame_end_i) begin
						if (grab_reg) state_next = acq_frame;
						else if (mode == mode_internal_single_frame) state_next = acq_armed;
						else state_next = acq_idle;
					end
				end
				acq_lines: begin
					if (line_i) lines_next = lines_reg + 16'h0001;
					case (mode)
						mode_window_first_input: if (a_fall_i || (line_i && lines_next >= max_lines_i))
							state_next = acq_idle;
						mode_window_two_inputs, mode_triggered_capture: if (b_rise_i
							|| (line_i && lines_next >= max_lines_i)) state_next = acq_idle;
						mode_window_level_repeat: if (a_fall_i) state_next = acq_idle;
							else if (frame_end_i && a_level_i) lines_next = 16'h0000;
							else if (frame_end_i) state_next = acq_idle;
						mode_streaming_capture, mode_gated_streaming: state_next = acq_lines;
						default: state_next = acq_idle;
					endcase
				end
				default: state_next = acq_idle;
			endcase
		end
		// freeze and abort act at once, except in untriggered mode or with free_i set
		if (stop_i && !(free_i || mode == mode_untriggered)) begin
			state_next = acq_idle;
			grab_next = 1'b0;
			self_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= acq_idle;
			grab_reg <= 1'b0;
			cmd_grab_reg <= 1'b0;
			self_reg <= 1'b0;
			lines_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			grab_reg <= grab_next;
			cmd_grab_reg <= cmd_grab_next;
			self_reg <= self_next;
			lines_reg <= lines_next;
		end
	end

	// outputs
	assign capture_o = (state_reg == acq_frame) || (state_reg == acq_lines);
	assign accept_o = capture_o && (mode != mode_gated_streaming || qual_i);
	assign pending_o = (state_reg == acq_armed);
	assign grabbing_o = grab_reg;
endmodule
`default_nettype wire

// ---- logic/vertical_trigger_control.sv ----
// vertical trigger control: wishbone registers, trigger pick, two capture engines
// assumes synchronous pins at 125 MHz and a classic wishbone master
// Functional notes
// - free-run ignores both triggers and acquires continuously
// - deferred command mode: trigger A starts latest snap or grab; B ignored
// - grab-hold mode: A asserts grab, A deasserts freeze
// - single-frame mode: each A assertion captures exactly one frame
// - internal single-frame: self triggers, external inputs ignored
// - window mode: lines start on A, stop on max or A deassert
// - two-input window: lines start on A, stop on max or B assert
// - level repeat: stops on A deassert, repeats frame while A held
// - streaming: A starts unbounded continuous acquisition
// - gated streaming: data accepted only while qualifier valid
// - polarity of A selects rising or falling edge detect
// - polarity of B selects rising or falling edge detect
// - routing: shared, A to J and B to K, or K free runs
// - source choice picks trigger origin; keep code leaves it unchanged
// - host reads back mode, routing and both polarities
// - software triggers act like hardware ones, without polarity
// - snap or grab pend until trigger; freeze and abort act at once, except on a free-running engine
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module vertical_trigger_control
	import vtrig_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [4:0] trig_a_pins_i,
	input wire logic trig_b_i,
	input wire logic camera_frame_valid_i,
	input wire logic internal_trigger_generator_i,
	input wire logic frame_start_i,
	input wire logic frame_end_i,
	input wire logic line_i,
	input wire logic qualifier_i,
	output logic capture_j_o,
	output logic capture_k_o,
	output logic accept_j_o,
	output logic accept_k_o
);
	logic [3:0] mode_reg, mode_next;
	logic [1:0] route_reg, route_next;
	logic pola_reg, pola_next;
	logic polb_reg, polb_next;
	logic [2:0] src_reg, src_next;
	logic [15:0] lines_reg, lines_next;
	logic swa_reg, swa_next;
	logic swb_reg, swb_next;
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic hw_a;
	logic a_lvl, a_rise, a_fall;
	logic b_lvl, b_rise, b_fall;
	logic swa_prev_reg, swa_prev_next;
	logic swb_prev_reg, swb_prev_next;
	logic sw_a_rise, sw_a_fall, sw_b_rise, sw_b_fall;
	logic ta_lvl, ta_rise, ta_fall, tb_lvl, tb_rise, tb_fall;
	logic k_a_lvl, k_a_rise, k_a_fall;
	logic wr, cmd_wr;
	logic snap, grab, stop, k_free;
	logic pend_j, pend_k, grab_j, grab_k;
	logic [31:0] status;

	// a write lands on the edge at which the master samples ack high
	assign wr = cyc_i && stb_i && we_i && ack_reg;
	assign cmd_wr = wr && adr_i == CMD_OFS && sel_i[0];
	assign snap = cmd_wr && dat_i[CMD_SNAP_BIT];
	assign grab = cmd_wr && dat_i[CMD_GRAB_BIT];
	assign stop = cmd_wr && (dat_i[CMD_FREEZE_BIT] || dat_i[CMD_ABORT_BIT]); // freeze and abort alike

	// trigger settings held in the mode register
	always_comb begin
		mode_next = mode_reg;
		route_next = route_reg;
		pola_next = pola_reg;
		polb_next = polb_reg;
		src_next = src_reg;
		if (wr && adr_i == MODE_OFS) begin
			if (sel_i[0]) begin
				mode_next = dat_i[MODE_LSB +: 4];
				route_next = dat_i[ROUTE_LSB +: 2];
				pola_next = dat_i[POLA_BIT];
				polb_next = dat_i[POLB_BIT];
			end
			// the keep code leaves the origin as it was
			if (sel_i[1] && source_t'(dat_i[SRC_LSB +: 3]) != source_keep) begin
				src_next = dat_i[SRC_LSB +: 3];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_reg <= MODE_RESET;
			route_reg <= ROUTE_RESET;
			pola_reg <= polarity_rising;
			polb_reg <= polarity_rising;
			src_reg <= SRC_RESET;
		end else begin
			mode_reg <= mode_next;
			route_reg <= route_next;
			pola_reg <= pola_next;
			polb_reg <= polb_next;
			src_reg <= src_next;
		end
	end

	// maximum line count, each byte lane written under its own select
	always_comb begin
		lines_next = lines_reg;
		if (wr && adr_i == LINES_OFS) begin
			if (sel_i[0]) lines_next[7:0] = dat_i[7:0];
			if (sel_i[1]) lines_next[15:8] = dat_i[15:8];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lines_reg <= LINES_RESET;
		end else begin
			lines_reg <= lines_next;
		end
	end

	// software trigger levels and their history for edge finding
	always_comb begin
		swa_next = swa_reg;
		swb_next = swb_reg;
		swa_prev_next = swa_reg;
		swb_prev_next = swb_reg;
		if (cmd_wr && dat_i[CMD_SWA_BIT]) swa_next = dat_i[CMD_SWA_LVL_BIT];
		if (cmd_wr && dat_i[CMD_SWB_BIT]) swb_next = dat_i[CMD_SWB_LVL_BIT];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			swa_reg <= 1'b0;
			swb_reg <= 1'b0;
			swa_prev_reg <= 1'b0;
			swb_prev_reg <= 1'b0;
		end else begin
			swa_reg <= swa_next;
			swb_reg <= swb_next;
			swa_prev_reg <= swa_prev_next;
			swb_prev_reg <= swb_prev_next;
		end
	end

	// live status word for the host
	assign status = {26'h0, grab_k, grab_j, pend_k, pend_j, capture_k_o, capture_j_o};

	// bus answer one cycle after the request, read data with it
	always_comb begin
		ack_next = cyc_i && stb_i && !ack_reg; // drops after one cycle even if stb stays
		rdat_next = rdat_reg;
		if (cyc_i && stb_i && !ack_reg) begin
			case (adr_i)
				// settings read back as programmed
				MODE_OFS: rdat_next = {21'h0, src_reg, polb_reg, pola_reg, route_reg, mode_reg};
				CMD_OFS: rdat_next = {24'h0, swb_reg, 1'b0, swa_reg, 5'h0};
				STATUS_OFS: rdat_next = status;
				LINES_OFS: rdat_next = {16'h0, lines_reg};
				default: rdat_next = UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = rdat_reg;

	// trigger A origin multiplexer
	always_comb begin
		case (source_t'(src_reg))
			source_differential: hw_a = trig_a_pins_i[0];
			source_single_ended: hw_a = trig_a_pins_i[1];
			source_isolated: hw_a = trig_a_pins_i[2];
			source_frame_valid: hw_a = camera_frame_valid_i;
			source_internal_generator: hw_a = internal_trigger_generator_i;
			default: hw_a = 1'b0;
		endcase
	end

	// synchronise and edge detect each trigger
	trig_edge_detect u_edge_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.trig_i(hw_a),
		.polarity_i(pola_reg),
		.level_o(a_lvl),
		.assert_o(a_rise),
		.deassert_o(a_fall)
	);

	// trigger B has a single pin and its own polarity
	trig_edge_detect u_edge_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.trig_i(trig_b_i),
		.polarity_i(polb_reg),
		.level_o(b_lvl),
		.assert_o(b_rise),
		.deassert_o(b_fall)
	);

	// software edges from the level history
	assign sw_a_rise = swa_reg & ~swa_prev_reg;
	assign sw_a_fall = ~swa_reg & swa_prev_reg;
	assign sw_b_rise = swb_reg & ~swb_prev_reg;
	assign sw_b_fall = ~swb_reg & swb_prev_reg;

	// software triggers merge after polarity
	// a pin edge is masked while software already holds the trigger up
	assign ta_lvl = a_lvl | swa_reg;
	assign ta_rise = (a_rise & ~swa_reg) | (sw_a_rise & ~a_lvl);
	assign ta_fall = (a_fall & ~swa_reg) | (sw_a_fall & ~a_lvl);
	assign tb_lvl = b_lvl | swb_reg;
	assign tb_rise = (b_rise & ~swb_reg) | (sw_b_rise & ~b_lvl);
	assign tb_fall = (b_fall & ~swb_reg) | (sw_b_fall & ~b_lvl);

	// engine K takes B as its start trigger when split
	always_comb begin
		if (route_reg == routing_split) begin
			k_a_lvl = tb_lvl;
			k_a_rise = tb_rise;
			k_a_fall = tb_fall;
		end else begin
			k_a_lvl = ta_lvl;
			k_a_rise = ta_rise;
			k_a_fall = ta_fall;
		end
	end

	// K runs free of any trigger in that routing
	assign k_free = route_reg == routing_one_free;

	// engine J always follows trigger A

	engine_window u_engine_j (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.mode_i(mode_reg),
		.free_i(1'b0),
		.a_level_i(ta_lvl),
		.a_rise_i(ta_rise),
		.a_fall_i(ta_fall),
		.b_rise_i(tb_rise),
		.snap_i(snap),
		.grab_i(grab),
		.stop_i(stop),
		.frame_start_i(frame_start_i),
		.frame_end_i(frame_end_i),
		.line_i(line_i),
		.qual_i(qualifier_i),
		.max_lines_i(lines_reg),
		.capture_o(capture_j_o),
		.accept_o(accept_j_o),
		.pending_o(pend_j),
		.grabbing_o(grab_j)
	);

	// engine K follows A, or B when split, or nothing when free
	engine_window u_engine_k (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.mode_i(mode_reg),
		.free_i(k_free),
		.a_level_i(k_a_lvl),
		.a_rise_i(k_a_rise),
		.a_fall_i(k_a_fall),
		.b_rise_i(tb_rise),
		.snap_i(snap),
		.grab_i(grab),
		.stop_i(stop),
		.frame_start_i(frame_start_i),
		.frame_end_i(frame_end_i),
		.line_i(line_i),
		.qual_i(qualifier_i),
		.max_lines_i(lines_reg),
		.capture_o(capture_k_o),
		.accept_o(accept_k_o),
		.pending_o(pend_k),
		.grabbing_o(grab_k)
	);
endmodule
`default_nettype wire

// ---- tb/vtrig_checker.sv ----
// port checker for vertical_trigger_control
// assumes a bind from the testbench and one clock domain
`timescale 1ns/1ps
`default_nettype none
module vtrig_checker
	import vtrig_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic [4:0] trig_a_pins_i,
	input wire logic trig_b_i,
	input wire logic qualifier_i,
	input wire logic capture_j_o,
	input wire logic capture_k_o,
	input wire logic accept_j_o,
	input wire logic accept_k_o
);
	logic [10:0] m_reg, m_next;
	logic [3:0] age_reg, age_next;
	logic wr, a_lvl, b_lvl;
	// shadow of the mode fields and cycles since the last write
	assign wr = ack_o && cyc_i && stb_i && we_i;
	assign a_lvl = trig_a_pins_i[0] ^ m_reg[6];
	assign b_lvl = trig_b_i ^ m_reg[7];
	always_comb begin
		m_next = m_reg;
		age_next = (age_reg == 4'hF) ? age_reg : age_reg + 4'h1;
		if (wr) begin
			age_next = 4'h0;
		end
		if (wr && adr_i == MODE_OFS && sel_i[0]) begin
			m_next[7:0] = dat_i[7:0];
		end
		if (wr && adr_i == MODE_OFS && sel_i[1] && dat_i[10:8] != 3'h7) begin
			m_next[10:8] = dat_i[10:8];
		end
	end
	always_ff @(posedge clk_i) begin
		m_reg <= rst_i ? 11'h000 : m_next;
		age_reg <= rst_i ? 4'h0 : age_next;
	end
	// bus, reset and capture relations
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
	a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
	a_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !capture_j_o && !capture_k_o)
		else $error("busy after reset");
	a_unmapped_zero: assert property (ack_o && !we_i && adr_i[1:0] != 2'h0 |-> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_accept_j: assert property (accept_j_o |-> capture_j_o) else $error("accept j idle");
	a_accept_k: assert property (accept_k_o |-> capture_k_o) else $error("accept k idle");
	a_gate_qual: assert property (m_reg[3:0] == 4'hA && capture_j_o |-> accept_j_o == qualifier_i)
		else $error("gate ignores qualifier");
	a_free_runs: assert property (m_reg[3:0] == 4'h0 && age_reg == 4'hF |-> capture_j_o)
		else $error("free run stopped");
	a_window_stop: assert property ((m_reg[3:0] == 4'h5 && m_reg[10:8] == 3'h0 && age_reg == 4'hF && !a_lvl) [*6]
		|-> !capture_j_o) else $error("window open without A");
	a_b_stops: assert property (m_reg[10:4] == 7'h00 && m_reg[3:0] == 4'h6 && age_reg == 4'hF && $rose(b_lvl)
		|-> ##5 !capture_j_o) else $error("B did not stop");
endmodule
`default_nettype wire

// ---- tb/camera_model.sv ----
// free-running camera timing: frame start, eight lines, frame end, qualifier
// assumes one clock; the camera is not reset by triggers
`timescale 1ns/1ps
`default_nettype none
module camera_model (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic frame_start_o,
	output logic frame_end_o,
	output logic line_o,
	output logic qual_o
);
	logic [4:0] cnt_reg, cnt_next;
	// position in a twenty cycle frame
	always_comb begin
		cnt_next = (cnt_reg == 5'h13) ? 5'h00 : cnt_reg + 5'h01;
	end
	always_ff @(posedge clk_i) begin
		cnt_reg <= rst_i ? 5'h00 : cnt_next;
	end
	// one-cycle pulses, and the qualifier from bit 2, decoded from the position
	assign frame_start_o = cnt_reg == 5'h01;
	assign frame_end_o = cnt_reg == 5'h13;
	assign line_o = cnt_reg[0] && cnt_reg > 5'h02 && cnt_reg < 5'h12;
	assign qual_o = cnt_reg[2];
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for vertical_trigger_control
// assumes package, checker and camera model compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import vtrig_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, tb_b, fs, fe, ln, ql, cap_j, cap_k, acc_j, acc_k, cj_d, ck_d;
	logic [3:0] adr;
	logic [4:0] pins;
	logic [31:0] dat, rd, q;
	int num_errors, check_count, rj, rk, nl, r, n;
	vertical_trigger_control i_vertical_trigger_control (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rd), .ack_o(ack),
		.trig_a_pins_i(pins), .trig_b_i(tb_b), .camera_frame_valid_i(pins[3]),
		.internal_trigger_generator_i(pins[4]),
		.frame_start_i(fs), .frame_end_i(fe), .line_i(ln), .qualifier_i(ql), .capture_j_o(cap_j),
		.capture_k_o(cap_k), .accept_j_o(acc_j), .accept_k_o(acc_k));
	camera_model i_camera_model (.clk_i(clk_i), .rst_i(rst_i), .frame_start_o(fs), .frame_end_o(fe),
		.line_o(ln), .qual_o(ql));
	// 125 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// capture starts and lines taken
	always @(posedge clk_i) begin
		cj_d <= cap_j;
		ck_d <= cap_k;
		rj = rj + int'(cap_j && !cj_d);
		rk = rk + int'(cap_k && !ck_d);
		nl = nl + int'(cap_j && ln);
	end
	task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", s, exp, got);
		end
	endtask
	task automatic cyc_n(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 20);
		q = rd;
		chk("bus ack", ack, 1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// new mode from idle pins, then abort whatever ran
	task automatic setm(input logic [31:0] v);
		pins <= 5'h00;
		tb_b <= 1'b0;
		wb(1'b1, MODE_OFS, v);
		cyc_n(4);
		wb(1'b1, CMD_OFS, 32'h0000_0008);
		cyc_n(2);
	endtask
	task automatic tog_a(input int i, input int w);
		pins[i] <= ~pins[i];
		cyc_n(w);
		pins[i] <= ~pins[i];
		cyc_n(2);
	endtask
	task automatic tog_b(input int w);
		tb_b <= ~tb_b;
		cyc_n(w);
		tb_b <= ~tb_b;
		cyc_n(2);
	endtask
	task automatic t_regs;
		logic [31:0] v;
		wb(1'b0, MODE_OFS, 0);
		chk("mode reset", q, 0);
		wb(1'b0, LINES_OFS, 0);
		chk("lines reset", q, 32'h0000_0400);
		for (int i = 0; i < 15; i++) begin
			v = {21'h0, 3'(i % 5), 1'(i), 1'(i / 2), 2'(i % 3), 4'(i % 11)};
			setm(v);
			wb(1'b0, MODE_OFS, 0);
			chk("mode readback", q, v);
		end
		wb(1'b1, MODE_OFS, v | 32'h0000_0700);
		wb(1'b1, 4'h2, 32'hFFFF_FFFF);
		wb(1'b0, 4'h2, 0);
		chk("unmapped", q, 0);
		wb(1'b0, MODE_OFS, 0);
		chk("source kept", q, v);
		$display("t_regs done");
	endtask
	task automatic t_trig;
		setm(0);
		tog_a(0, 6);
		tog_b(6);
		r = rj;
		cyc_n(40);
		chk("free run", {cap_j, cap_k, 30'(rj - r)}, 32'hC000_0000);
		setm(3);
		r = rj;
		tog_b(6);
		cyc_n(40);
		chk("b ignored", rj - r, 0);
		tog_a(0, 12);
		cyc_n(50);
		chk("one frame", rj - r, 1);
		setm(32'h0000_0043);
		pins[0] <= 1'b1;
		cyc_n(8);
		r = rj;
		tog_a(0, 12);
		cyc_n(50);
		chk("falling a", rj - r, 1);
		wb(1'b1, CMD_OFS, 32'h0000_0030);
		cyc_n(30);
		chk("soft a", rj - r, 2);
		wb(1'b1, CMD_OFS, 32'h0000_0010);
		setm(32'h0000_0093);
		tb_b <= 1'b1;
		cyc_n(8);
		r = rj;
		n = rk;
		tog_b(12);
		cyc_n(50);
		chk("split b", {16'(rj - r), 16'(rk - n)}, 32'h0000_0001);
		setm(32'h0000_0023);
		cyc_n(30);
		chk("k free", cap_k, 1);
		setm(32'h0000_0103);
		r = rj;
		tog_a(0, 12);
		cyc_n(50);
		chk("wrong source", rj - r, 0);
		tog_a(1, 12);
		cyc_n(50);
		chk("single ended", rj - r, 1);
		setm(32'h0000_0303);
		r = rj;
		tog_a(3, 12);
		cyc_n(50);
		chk("frame valid source", rj - r, 1);
		$display("t_trig done");
	endtask
	task automatic t_lines;
		wb(1'b1, LINES_OFS, 32'h0000_0064);
		setm(5);
		pins[0] <= 1'b1;
		cyc_n(10);
		chk("window on", cap_j, 1);
		pins[0] <= 1'b0;
		cyc_n(16);
		chk("window off", cap_j, 0);
		wb(1'b1, LINES_OFS, 32'h0000_0003);
		n = nl;
		pins[0] <= 1'b1;
		cyc_n(60);
		chk("max lines", {cap_j, 31'(nl - n)}, 32'h0000_0003);
		wb(1'b1, LINES_OFS, 32'h0000_0064);
		setm(6);
		tog_a(0, 4);
		cyc_n(20);
		chk("a low keeps", cap_j, 1);
		tog_b(4);
		cyc_n(2);
		chk("b stops", cap_j, 0);
		setm(7);
		pins[0] <= 1'b1;
		cyc_n(50);
		chk("level repeat", cap_j, 1);
		pins[0] <= 1'b0;
		cyc_n(30);
		chk("level end", cap_j, 0);
		$display("t_lines done");
	endtask
	task automatic t_cmd;
		setm(1);
		r = rj;
		wb(1'b1, CMD_OFS, 32'h0000_0001);
		tog_b(6);
		cyc_n(40);
		wb(1'b0, STATUS_OFS, 0);
		chk("snap pends", {q[2], 31'(rj - r)}, 32'h8000_0000);
		tog_a(0, 6);
		cyc_n(50);
		chk("snap once", rj - r, 1);
		wb(1'b1, CMD_OFS, 32'h0000_0002);
		tog_a(0, 6);
		cyc_n(50);
		wb(1'b0, STATUS_OFS, 0);
		chk("grab runs", q[4], 1);
		wb(1'b1, CMD_OFS, 32'h0000_0004);
		wb(1'b0, STATUS_OFS, 0);
		chk("freeze now", {q[4], q[0]}, 0);
		setm(2);
		pins[0] <= 1'b1;
		cyc_n(10);
		wb(1'b0, STATUS_OFS, 0);
		chk("hold grab", q[4], 1);
		pins[0] <= 1'b0;
		cyc_n(10);
		wb(1'b0, STATUS_OFS, 0);
		chk("hold freeze", q[4], 0);
		setm(4);
		r = rj;
		cyc_n(80);
		chk("self trigger", rj - r > 1, 1);
		setm(9);
		tog_a(0, 4);
		cyc_n(60);
		chk("stream", cap_j, 1);
		setm(10);
		tog_a(0, 4);
		cyc_n(10);
		repeat (8) begin
			chk("gated", {cap_j, acc_j, cap_k, acc_k}, {1'b1, ql, 1'b1, ql});
			cyc_n(1);
		end
		$display("t_cmd done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// watchdog, far beyond the expected run
	initial begin
		#200000;
		num_errors++;
		tally_and_finish;
	end
	// reset, then the scenarios
	initial begin
		{rst_i, cyc, stb, we, tb_b, cj_d, ck_d} = 7'h40;
		{adr, pins, dat} = 0;
		{num_errors, check_count, rj, rk, nl} = 0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs;
		t_trig;
		t_lines;
		t_cmd;
		tally_and_finish;
	end
endmodule
bind vertical_trigger_control vtrig_checker i_vtrig_checker (.*);
`default_nettype wire
